// ### verilog/spi_baud_and_status_flags.sv
// The implementer's own choices: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
// serial interface bit rate generation, status flags and register slave
// What this block does
// RL1: prescale field bits 6:4 divides bus clock by field plus one.
// RL2: rate field bits 2:0 divides further by two to power field plus one.
// RL3: bus clock feeds prescaler, then divider, giving master bit clock.
// RL4: bit rate register is readable and writable at any time.
// RL5: unused status bits read zero; status writes are ignored.
// RL6: receive full flag sets when a transfer completes.
// RL7: receive full clears on status read with flag set then data read.
// RL8: transmit empty high while buffer free; cleared by armed status read then data write.
// RL9: data write without a prior status read showing transmit empty is ignored.
// RL10: interrupt when transmit empty set and transmit interrupt enabled.
// RL11: transmit empty sets when a byte moves from buffer into shifter.
// RL12: idle interface loads written byte into shifter within two bus cycles.
// RL13: after a shift, queued byte loads and flag sets; else nothing moves.
// RL14: mode fault sets when master and slave select input driven low.
// RL15: mode fault input only with master, fault enable, no select output.
// RL16: mode fault clears on status read with flag set then control one write.
// RL17: disabling halts transfer, resets machines, clears receive full, sets transmit empty.
// RL18: interrupt when receive full or mode fault set and receive enable set.
// RL19: master clock equals bus clock over prescale times rate divisor.
module spi_baud_and_status_flags
	import spi_flags_pkg::*;
(
	// clock and reset
	input  wire logic              mclk,
	input  wire logic              rst,
	// avalon-mm slave
	input  wire logic [addr_w-1:0] address,
	input  wire logic              read,
	input  wire logic              write,
	input  wire logic [31:0]       writedata,
	input  wire logic [3:0]        byteenable,
	output logic [31:0]            readdata,
	output logic                   waitrequest,
	// serial link
	output logic                   sck,
	output logic                   mosi,
	input  wire logic              miso,
	input  wire logic              ss_n_in,
	output logic                   ss_n_out,
	output logic                   ss_n_oe,
	// interrupts
	output logic                   irq
);
	typedef enum logic [2:0] {
		st_idle  = 3'b001,
		st_shift = 3'b010,
		st_done  = 3'b100
	} shift_state_t;

	// ==================================================
	// registers
	logic [7:0]       ctrl_one_q;
	logic [7:0]       ctrl_two_q;
	logic [7:0]       bit_rate_q;
	logic [irq_w-1:0] irq_status_q;
	logic [irq_w-1:0] irq_mask_q;
	logic             rx_full_q;
	logic             tx_empty_q;
	logic             mode_flt_q;
	logic             rx_arm_q;
	logic             tx_arm_q;
	logic             mf_arm_q;
	logic [7:0]       tx_buf_q;
	logic [7:0]       rx_buf_q;
	logic [7:0]       shift_q;
	logic [3:0]       edge_cnt_q;
	logic             ack_q;
	shift_state_t     state_q;

	logic             enabled;
	logic             is_master;
	logic             fault_input;
	logic             half_tick;
	logic             acc;
	logic             rd_flags;
	logic             rd_data;
	logic             wr_data;
	logic             wr_ctrl_one;
	logic             tx_take;
	logic             load_shifter;
	logic             frame_done;
	logic [irq_w-1:0] irq_events;

	function automatic logic hit(input logic [addr_w-1:0] a, input logic [addr_w-1:0] off);
		hit = (a == off);
	endfunction : hit

	assign enabled     = ctrl_one_q[enable_bit];
	assign is_master   = ctrl_one_q[master_bit];
	// RL15
	assign fault_input = is_master && ctrl_two_q[mode_fault_enable_bit] && !ctrl_one_q[select_output_enable_bit];

	// ==================================================
	// bus handshake: one wait cycle, accept on the acknowledge cycle
	assign acc         = (read || write) && ack_q;
	assign rd_flags    = acc && read && hit(address, addr_w'(flags_off));
	assign rd_data     = acc && read && hit(address, data_off);
	assign wr_data     = acc && write && byteenable[0] && hit(address, data_off);
	assign wr_ctrl_one = acc && write && byteenable[0] && hit(address, addr_w'(ctrl_one_off));
	assign tx_take     = wr_data && tx_arm_q; // RL9

	always_ff @(posedge mclk) begin
		if (rst) begin
			ack_q       <= 1'b0;
			waitrequest <= 1'b1;
		end else begin
			ack_q       <= (read || write) && !ack_q;
			waitrequest <= !((read || write) && !ack_q);
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			readdata <= 32'h0000_0000;
		end else if ((read || write) && !ack_q) begin
			readdata <= 32'h0000_0000;
			if (read) begin
				unique case (address)
					addr_w'(ctrl_one_off): readdata[7:0] <= ctrl_one_q;
					addr_w'(ctrl_two_off): readdata[7:0] <= ctrl_two_q;
					addr_w'(bit_rate_off): readdata[7:0] <= bit_rate_q; // RL4
					addr_w'(flags_off): begin
						readdata[rx_full_bit]  <= rx_full_q; // RL5
						readdata[tx_empty_bit] <= tx_empty_q;
						readdata[mode_flt_bit] <= mode_flt_q;
					end
					data_off:       readdata[7:0]       <= rx_buf_q;
					irq_status_off: readdata[irq_w-1:0] <= irq_status_q;
					irq_mask_off:   readdata[irq_w-1:0] <= irq_mask_q;
					default:        readdata            <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ==================================================
	// control registers; status writes fall through untouched
	always_ff @(posedge mclk) begin
		if (rst) begin
			ctrl_one_q <= ctrl_one_rst;
			ctrl_two_q <= ctrl_two_rst;
			bit_rate_q <= bit_rate_rst;
			irq_mask_q <= '0;
		end else if (acc && write && byteenable[0]) begin
			if (hit(address, addr_w'(ctrl_one_off))) begin
				ctrl_one_q <= writedata[7:0];
			end
			if (hit(address, addr_w'(ctrl_two_off))) begin
				ctrl_two_q <= writedata[7:0];
			end
			if (hit(address, addr_w'(bit_rate_off))) begin
				bit_rate_q <= writedata[7:0] & 8'h77; // RL4
			end
			if (hit(address, irq_mask_off)) begin
				irq_mask_q <= writedata[irq_w-1:0];
			end
		end
	end

	// ==================================================
	// bit clock generation
	rate_divider #() u_rate (
		.mclk                (mclk),
		.rst                 (rst),
		.run                 (enabled && is_master && state_q == st_shift),
		.prescale_select     (bit_rate_q[presc_lo+2:presc_lo]),
		.rate_divider_select (bit_rate_q[rate_lo+2:rate_lo]),
		.half_tick           (half_tick)
	);

	// ==================================================
	// shifter: even edges sample, odd edges shift (mode 0 style, msb first)
	// a loaded byte starts right away; in idle the load happens the cycle after the write
	assign load_shifter = !tx_empty_q && (state_q == st_idle || state_q == st_done); // RL12 RL13
	assign frame_done   = (state_q == st_shift) && half_tick &&
	                      (edge_cnt_q == 4'(2 * bits_per_frame - 1));

	always_ff @(posedge mclk) begin
		if (rst || !enabled) begin
			state_q    <= st_idle; // RL17
			edge_cnt_q <= 4'h0;
			shift_q    <= 8'h00;
			sck        <= 1'b0;
			mosi       <= 1'b0;
			ss_n_out   <= 1'b1;
			ss_n_oe    <= 1'b0;
		end else begin
			ss_n_oe <= is_master && ctrl_two_q[mode_fault_enable_bit] && ctrl_one_q[select_output_enable_bit];
			unique case (state_q)
				st_idle, st_done: begin
					sck      <= 1'b0;
					ss_n_out <= 1'b1;
					state_q  <= st_idle;
					if (load_shifter && is_master) begin
						shift_q    <= tx_buf_q; // RL11
						mosi       <= tx_buf_q[7];
						edge_cnt_q <= 4'h0;
						ss_n_out   <= 1'b0;
						state_q    <= st_shift;
					end
				end
				st_shift: begin
					if (half_tick) begin
						sck        <= !sck;
						edge_cnt_q <= edge_cnt_q + 4'h1;
						if (!edge_cnt_q[0]) begin
							shift_q <= {shift_q[6:0], miso};
						end else begin
							mosi <= shift_q[7];
						end
						if (frame_done) begin
							state_q <= st_done;
						end
					end
				end
			endcase
		end
	end

	// receive buffer keeps the old byte on overrun
	always_ff @(posedge mclk) begin
		if (rst) begin
			rx_buf_q <= 8'h00;
		end else if (frame_done && !rx_full_q) begin
			rx_buf_q <= shift_q;
		end
	end

	// ==================================================
	// status flags: for receive full and mode fault a set in the same cycle as its clear wins; for transmit empty the clear wins
	always_ff @(posedge mclk) begin
		if (rst || !enabled) begin
			rx_full_q <= 1'b0; // RL17
			rx_arm_q  <= 1'b0;
		end else begin
			if (rd_flags && rx_full_q) begin
				rx_arm_q <= 1'b1;
			end else if (rd_data) begin
				rx_arm_q <= 1'b0;
			end
			if (frame_done) begin
				rx_full_q <= 1'b1; // RL6
			end else if (rd_data && rx_arm_q) begin
				rx_full_q <= 1'b0; // RL7
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst || !enabled) begin
			tx_empty_q <= 1'b1; // RL17
			tx_arm_q   <= 1'b0;
			tx_buf_q   <= 8'h00;
		end else begin
			if (rd_flags && tx_empty_q) begin
				tx_arm_q <= 1'b1;
			end else if (wr_data) begin
				tx_arm_q <= 1'b0;
			end
			if (tx_take) begin
				tx_buf_q   <= writedata[7:0];
				tx_empty_q <= 1'b0; // RL8 RL9
			end else if (load_shifter && is_master) begin
				tx_empty_q <= 1'b1; // RL11 RL13
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			mode_flt_q <= 1'b0;
			mf_arm_q   <= 1'b0;
		end else begin
			if (rd_flags && mode_flt_q) begin
				mf_arm_q <= 1'b1;
			end else if (wr_ctrl_one) begin
				mf_arm_q <= 1'b0;
			end
			if (enabled && fault_input && !ss_n_in) begin
				mode_flt_q <= 1'b1; // RL14 RL15
			end else if (wr_ctrl_one && mf_arm_q) begin
				mode_flt_q <= 1'b0; // RL16
			end
		end
	end

	// ==================================================
	// interrupts: sticky event bits, write one to clear, mask gates output
	assign irq_events[irq_tx_bit] = tx_empty_q && ctrl_one_q[tx_ie_bit]; // RL10
	assign irq_events[irq_rx_bit] = rx_full_q && ctrl_one_q[rx_ie_bit]; // RL18
	assign irq_events[irq_mf_bit] = mode_flt_q && ctrl_one_q[rx_ie_bit]; // RL18

	always_ff @(posedge mclk) begin
		if (rst) begin
			irq_status_q <= '0;
		end else begin
			for (int i = 0; i < irq_w; i++) begin
				if (irq_events[i]) begin
					irq_status_q[i] <= 1'b1;
				end else if (acc && write && byteenable[0] && hit(address, irq_status_off) && writedata[i]) begin
					irq_status_q[i] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status_q & irq_mask_q);
		end
	end
endmodule : spi_baud_and_status_flags

// ### include/spi_flags_pkg.sv
// register map, field layout and constants of the serial rate and flag block
package spi_flags_pkg;
	// ==================================================
	// register offsets (byte addresses, one word each)
	localparam logic [3:0] ctrl_one_off    = 4'h0;
	localparam logic [3:0] ctrl_two_off    = 4'h4;
	localparam logic [3:0] bit_rate_off    = 4'h8;
	localparam logic [3:0] flags_off       = 4'hC;
	// ==================================================
	// data register sits above the flag registers
	localparam logic [4:0] data_off        = 5'h10;
	localparam logic [4:0] irq_status_off  = 5'h14;
	localparam logic [4:0] irq_mask_off    = 5'h18;
	localparam int         addr_w          = 5;
	// ==================================================
	// control register one fields
	localparam int rx_ie_bit    = 7;
	localparam int enable_bit   = 6;
	localparam int tx_ie_bit    = 5;
	localparam int master_bit   = 4;
	localparam int select_output_enable_bit     = 1;
	// control register two fields
	localparam int mode_fault_enable_bit   = 4;
	// bit rate fields
	localparam int presc_lo     = 4;
	localparam int rate_lo      = 0;
	// status fields
	localparam int rx_full_bit  = 7;
	localparam int tx_empty_bit = 5;
	localparam int mode_flt_bit = 4;
	// interrupt status/mask layout
	localparam int irq_tx_bit   = 0;
	localparam int irq_rx_bit   = 1;
	localparam int irq_mf_bit   = 2;
	localparam int irq_w        = 3;
	// ==================================================
	// reset values
	localparam logic [7:0] ctrl_one_rst = 8'h04;
	localparam logic [7:0] ctrl_two_rst = 8'h00;
	localparam logic [7:0] bit_rate_rst = 8'h00;
	localparam logic [7:0] flags_mask   = 8'hB0;
	localparam int         bits_per_frame = 8;
endpackage : spi_flags_pkg

// ### verilog/rate_divider.sv
`timescale 1ns/1ps
// prescaler followed by power-of-two divider, one bus clock enable pulse per bit half
module rate_divider
	import spi_flags_pkg::*;
(
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       rst,
	// control
	input  wire logic       run,
	input  wire logic [2:0] prescale_select,
	input  wire logic [2:0] rate_divider_select,
	// output: one pulse per half bit clock period
	output logic            half_tick
);
	logic [2:0] pre_q;
	logic [7:0] div_q;
	logic       pre_tick;
	logic [7:0] half_lim;

	// divisor prescale_select + 1
	assign pre_tick = (pre_q == prescale_select); // RL1 RL3
	// rate divisor 2^(sel+1), so half period is 2^sel prescaled ticks
	assign half_lim = 8'(8'h01 << rate_divider_select) - 8'h01; // RL2

	always_ff @(posedge mclk) begin
		if (rst || !run || pre_tick) begin
			pre_q <= 3'h0;
		end else begin
			pre_q <= pre_q + 3'h1;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst || !run) begin
			div_q     <= 8'h00;
			half_tick <= 1'b0;
		end else begin
			half_tick <= 1'b0;
			if (pre_tick) begin
				if (div_q >= half_lim) begin
					div_q     <= 8'h00;
					half_tick <= 1'b1; // RL3 RL19
				end else begin
					div_q <= div_q + 8'h01;
				end
			end
		end
	end
endmodule : rate_divider

// ### tb/spi_slave_model.sv
// behavioural serial slave on the far side of the master link
`timescale 1ns/1ps
module spi_slave_model (
	// link
	input wire logic	sck,
	input wire logic	mosi,
	input wire logic	ss_n,
	output logic	miso,
	// bench side
	input wire logic [7:0]	reply,
	output logic [7:0]	got,
	output int	frames
);
	logic [7:0]	sh;
	int	bits;
	initial begin
		{miso, got, frames, bits} = '0;
	end
	// deselected line shows the inverse of its last bit and holds it until the next select
	always @(posedge ss_n) miso = ~miso;
	always @(negedge ss_n) begin
		sh = reply;
		bits = 0;
		miso = reply[7];
	end
	// sample on the rising edge; reload at byte end since select may stay low
	always @(posedge sck) if (!ss_n) begin
		sh = {sh[6:0], mosi};
		bits++;
		if (bits == 8) begin
			got = sh;
			frames++;
			bits = 0;
			sh = reply;
		end
	end
	always @(negedge sck) if (!ss_n) miso = sh[7];
endmodule : spi_slave_model

// ### tb/spi_flags_monitor.sv
// port checker for the rate and flag block
`timescale 1ns/1ps
module spi_flags_monitor
	import spi_flags_pkg::*;
(
	// clock and reset
	input wire logic	mclk,
	input wire logic	rst,
	// avalon-mm slave
	input wire logic [addr_w-1:0]	address,
	input wire logic	read,
	input wire logic	write,
	input wire logic [31:0]	writedata,
	input wire logic [3:0]	byteenable,
	input wire logic [31:0]	readdata,
	input wire logic	waitrequest,
	// serial link
	input wire logic	sck,
	input wire logic	mosi,
	input wire logic	miso,
	input wire logic	ss_n_in,
	input wire logic	ss_n_out,
	input wire logic	ss_n_oe,
	// interrupts
	input wire logic	irq
);
	logic [7:0]	rate_q;
	logic [2:0]	mask_q;
	logic [10:0]	gap_q;
	logic [3:0]	edges_q;
	logic	sck_q;
	wire	wr_ok = !waitrequest && write && byteenable[0];
	wire	rd_ok = !waitrequest && read;
	wire [10:0]	half = {7'h0, rate_q[6:4] + 4'h1} << rate_q[2:0];
	// ==========
	// register shadows; edge spacing counted every cycle, edges counted only mid-frame, 16 edges wrap to 0
	always_ff @(posedge mclk) begin
		if (rst) begin
			rate_q <= 8'h00;
			mask_q <= 3'h0;
			sck_q <= 1'b0;
			gap_q <= 11'h0;
			edges_q <= 4'h0;
		end else begin
			sck_q <= sck;
			gap_q <= (sck != sck_q) ? 11'h0 : gap_q + 11'h1;
			edges_q <= ss_n_out ? 4'h0 : edges_q + {3'h0, sck != sck_q};
			if (wr_ok && address == {1'b0, bit_rate_off})
				rate_q <= writedata[7:0];
			if (wr_ok && address == irq_mask_off)
				mask_q <= writedata[2:0];
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	a_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("request left waiting");
	a_wait_single: assert property (!waitrequest |=> waitrequest)
		else $error("answer held too long");
	a_flags_pad: assert property (rd_ok && address == {1'b0, flags_off}
		|-> readdata[31:8] == 24'h0 && !readdata[6] && readdata[3:0] == 4'h0)
		else $error("unused flag bits set");
	a_rate_back: assert property (rd_ok && address == {1'b0, bit_rate_off} |-> readdata == {24'h0, rate_q & 8'h77})
		else $error("rate register readback");
	a_unmapped_zero: assert property (rd_ok && address == 5'h1C |-> readdata == 32'h0)
		else $error("unmapped read not zero");
	a_half_period: assert property ($changed(sck) && !ss_n_out && edges_q != 4'h0 |-> gap_q == half - 11'h1)
		else $error("serial clock half period");
	a_idle_clock: assert property (ss_n_out |-> !sck)
		else $error("serial clock outside frame");
	a_mosi_shift: assert property ($changed(mosi) && !ss_n_out && edges_q != 4'h0 |-> $fell(sck))
		else $error("data moved off falling edge");
	a_irq_masked: assert property (mask_q == 3'h0 && $past(mask_q) == 3'h0 |-> !irq)
		else $error("masked interrupt raised");
	c_data_write: cover property (wr_ok && address == data_off);
	c_frame_edge: cover property (!ss_n_out && $changed(sck));
	c_irq_rise: cover property ($rose(irq));
endmodule : spi_flags_monitor
bind spi_baud_and_status_flags spi_flags_monitor mon_u (.mclk(mclk), .rst(rst), .address(address), .read(read),
	.write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
	.sck(sck), .mosi(mosi), .miso(miso), .ss_n_in(ss_n_in), .ss_n_out(ss_n_out), .ss_n_oe(ss_n_oe), .irq(irq));

// ### tb/tb_spi_baud_and_status_flags.sv
// register bus tests for the rate and flag block
`timescale 1ns/1ps
`define chk(g, e) begin samples_checked++; if ((g) !== (e)) begin err_total++; $display("unexpected t=%0t got %h exp %h", $time, g, e); end end
module tb_spi_baud_and_status_flags
	import spi_flags_pkg::*;
;
	localparam logic [4:0] c1_a = 5'(ctrl_one_off), c2_a = 5'(ctrl_two_off);
	localparam logic [4:0] rate_a = 5'(bit_rate_off), fl_a = 5'(flags_off);
	logic	mclk = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0, ss_drive = 1'b0;
	logic [4:0]	address = 5'h00;
	logic [31:0]	writedata = 32'h0, readdata;
	logic [3:0]	byteenable = 4'hF;
	logic	waitrequest, sck, mosi, miso, ss_n_out, ss_n_oe, irq, ss_pin;
	logic [7:0]	reply = 8'h00, got, v;
	logic [7:0]	cfg [4] = '{8'h00, 8'h12, 8'h71, 8'h27};
	int	err_total = 0, samples_checked = 0, frames, n;
	always #5 mclk = ~mclk;
	// select pin has a pull-up; a rival master pulls it low, or ss_n_out drives it while ss_n_oe is set
	assign ss_pin = ss_n_oe ? ss_n_out : !ss_drive;
	spi_baud_and_status_flags dut_u (.mclk(mclk), .rst(rst), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest), .sck(sck),
		.mosi(mosi), .miso(miso), .ss_n_in(ss_pin), .ss_n_out(ss_n_out), .ss_n_oe(ss_n_oe), .irq(irq));
	spi_slave_model peer_u (.sck(sck), .mosi(mosi), .ss_n(ss_n_out), .miso(miso), .reply(reply), .got(got),
		.frames(frames));
	// ==========
	// bus access: hold the request until waitrequest is seen low
	task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
		@(posedge mclk);
		address <= a;
		writedata <= {24'h0, d};
		read <= !wr;
		write <= wr;
		// no cycle count is assumed; only the watchdog ends a stuck wait
		do begin
			@(posedge mclk);
		end while (waitrequest !== 1'b0);
		v = readdata[7:0];
		read <= 1'b0;
		write <= 1'b0;
	endtask : bus
	task automatic rdx(input logic [4:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		`chk(v, e)
	endtask : rdx
	task automatic xfer(input logic [7:0] d);
		rdx(fl_a, 8'h20);
		bus(1'b1, data_off, d);
	endtask : xfer
	task automatic per(input int e);
		realtime t0;
		@(posedge sck);
		t0 = $realtime;
		@(posedge sck);
		`chk(int'(($realtime - t0) / 10.0), e)
	endtask : per
	task automatic wait_rx();
		v = 8'h00;
		for (int t = 0; t < 3000 && v[7] !== 1'b1; t++)
			bus(1'b0, fl_a, 8'h00);
		`chk(v, 8'hA0)
	endtask : wait_rx
	task automatic results();
		$display("compared %0d, mismatched %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : results
	initial begin
		// longest frame is about 6k cycles; the whole run stays far below this
		#300us;
		err_total++;
		results();
	end
	initial begin
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		rdx(rate_a, 8'h00);
		bus(1'b1, fl_a, 8'hFF);
		rdx(fl_a, 8'h20);
		bus(1'b1, rate_a, 8'hFF);
		byteenable <= 4'h0;
		bus(1'b1, rate_a, 8'h00);
		byteenable <= 4'hF;
		rdx(rate_a, 8'h77);
		bus(1'b1, 5'h1C, 8'hFF);
		rdx(5'h1C, 8'h00);
		$display("registers test done");
		bus(1'b1, c1_a, 8'h50);
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, rate_a, cfg[i]);
			reply <= ~cfg[i];
			xfer(8'hA5 ^ cfg[i]);
			per((2 * (int'(cfg[i][6:4]) + 1)) << cfg[i][2:0]);
			wait_rx();
			rdx(data_off, ~cfg[i]);
			rdx(fl_a, 8'h20);
			`chk(got, 8'hA5 ^ cfg[i])
		end
		bus(1'b1, rate_a, 8'h00);
		$display("rate test done");
		n = frames;
		xfer(8'h81);
		bus(1'b1, data_off, 8'h42);
		rdx(fl_a, 8'h20);
		bus(1'b1, data_off, 8'h24);
		rdx(fl_a, 8'h00);
		wait_rx();
		while (frames < n + 2) @(posedge mclk);
		`chk(got, 8'h24)
		bus(1'b1, c1_a, 8'h10);
		rdx(fl_a, 8'h20);
		$display("queue test done");
		bus(1'b1, c1_a, 8'h70);
		rdx(irq_status_off, 8'h01);
		`chk(irq, 1'b0)
		bus(1'b1, irq_mask_off, 8'h07);
		repeat (2) @(posedge mclk);
		`chk(irq, 1'b1)
		bus(1'b1, c1_a, 8'hD0);
		bus(1'b1, irq_status_off, 8'h07);
		repeat (2) @(posedge mclk);
		`chk(irq, 1'b0)
		xfer(8'h5A);
		wait_rx();
		repeat (2) @(posedge mclk);
		`chk(irq, 1'b1)
		rdx(data_off, reply);
		bus(1'b1, irq_status_off, 8'h07);
		repeat (2) @(posedge mclk);
		`chk(irq, 1'b0)
		$display("interrupt test done");
		ss_drive <= 1'b1;
		repeat (3) @(posedge mclk);
		rdx(fl_a, 8'h20);
		ss_drive <= 1'b0;
		bus(1'b1, c2_a, 8'h10);
		ss_drive <= 1'b1;
		repeat (3) @(posedge mclk);
		ss_drive <= 1'b0;
		bus(1'b1, c1_a, 8'hD0);
		rdx(fl_a, 8'h30);
		repeat (2) @(posedge mclk);
		`chk(irq, 1'b1)
		bus(1'b1, c1_a, 8'h50);
		rdx(fl_a, 8'h20);
		bus(1'b1, c1_a, 8'h52);
		repeat (2) @(posedge mclk);
		`chk(ss_n_oe, 1'b1)
		$display("fault test done");
		results();
	end
endmodule : tb_spi_baud_and_status_flags
